// file: core/osc_cfg_pkg.sv
// Purpose: Shared constants and types for the option byte and supply block
// Assumes: Option bytes arrive one per strobe from a non-volatile array
// Notes:   Bit positions inside the watchdog and oscillator bytes are fixed here
package osc_cfg_pkg;

	// Option byte indices in load order
	localparam logic [2:0] OSC_IDX_READOUT  = 3'h0;
	localparam logic [2:0] OSC_IDX_BOOT     = 3'h1;
	localparam logic [2:0] OSC_IDX_RESERVED = 3'h2;
	localparam logic [2:0] OSC_IDX_WATCHDOG = 3'h3;
	localparam logic [2:0] OSC_IDX_OSC      = 3'h4;
	localparam logic [2:0] OSC_IDX_LAST     = 3'h4;

	// Readout unlock value
	localparam logic [7:0] OSC_READOUT_UNLOCK = 8'hAA;

	// Boot area size codes
	localparam logic [7:0] OSC_BOOT_NONE    = 8'h00;
	localparam logic [7:0] OSC_BOOT_VECTORS = 8'h01;
	localparam logic [7:0] OSC_BOOT_TWO     = 8'h02;

	// Watchdog byte field positions
	localparam int OSC_POS_INDEP_HW    = 0;
	localparam int OSC_POS_INDEP_HALT  = 1;
	localparam int OSC_POS_WINDOW_HW   = 2;
	localparam int OSC_POS_WINDOW_HALT = 3;

	// Oscillator byte field positions
	localparam int OSC_POS_FAST_CNT = 0;
	localparam int OSC_POS_SLOW_CNT = 2;

	// Settle counts per two-bit code
	localparam logic [12:0] OSC_SETTLE_C0 = 13'h0001;
	localparam logic [12:0] OSC_SETTLE_C1 = 13'h0010;
	localparam logic [12:0] OSC_SETTLE_C2 = 13'h0200;
	localparam logic [12:0] OSC_SETTLE_C3 = 13'h1000;

	// Brownout level field: five levels plus off
	localparam logic [2:0] OSC_BOR_DEFAULT = 3'h0;
	localparam logic [2:0] OSC_BOR_MAX     = 3'h4;
	localparam logic [2:0] OSC_BOR_OFF     = 3'h7;
	localparam int         OSC_POS_BOR     = 4;

	// Reset values of the latched bytes
	localparam logic [7:0] OSC_RST_BYTE = 8'h00;

	// Low-voltage detector levels
	localparam logic [2:0] OSC_LVD_MAX = 3'h6;

	// Load sequencer states
	typedef enum logic [1:0] {
		OSC_WAIT_SUPPLY,
		OSC_FETCH,
		OSC_DONE
	} osc_load_state_t;

	// Decoded configuration bundle
	typedef struct packed {
		logic        readoutLock;
		logic [7:0]  bootAreaSize;
		logic        bootProtectRw;
		logic        indepDogHwStart;
		logic        indepDogHaltStop;
		logic        windowDogHwStart;
		logic        windowDogHaltReset;
		logic [12:0] fastOscSettleCount;
		logic [12:0] slowOscSettleCount;
		logic [2:0]  brownoutLevel;
		logic        brownoutOff;
	} osc_cfg_t;

endpackage : osc_cfg_pkg

// file: core/osc_option_supply.sv
// Purpose: Option byte loader, decoder and supply supervisor digital side
// Assumes: Comparator outputs are asynchronous; option bytes from a flash port
// Notes:   Core reset is held until every byte is fetched
`timescale 1ns/1ns
`default_nettype none

module osc_option_supply
	import osc_cfg_pkg::*;
(
	input  wire logic       clock,              // System clock, 25 MHz
	input  wire logic       reset_n,            // Synchronous reset, active low
	input  wire logic       porBelow,           // Power-on/down comparator low
	input  wire logic       brownoutBelow,      // Brownout comparator low
	input  wire logic       lvdBelow,           // Detector comparator low
	output logic            optReadStrobe,      // Request next option byte
	output logic [2:0]      optReadIndex,       // Option byte index
	input  wire logic       optReadValid,       // Option byte present
	input  wire logic [7:0] optReadData,        // Option byte value
	input  wire logic       haltRequest,        // Core entering halt/active-halt
	input  wire logic       lvdEnable,          // Software detector enable
	input  wire logic [2:0] lvdLevel,           // Software detector level
	input  wire logic       lvdIrqOnFall,       // Interrupt on falling crossing
	input  wire logic       lvdIrqOnRise,       // Interrupt on rising crossing
	input  wire logic       lvdIrqClear,        // Software clears detector flag
	input  wire logic       refOffInHalt,       // Switch reference off in halt
	output logic            coreReset,          // Core held in reset
	output osc_cfg_t        cfg,                // Decoded option settings
	output logic [7:0]      readoutProtectByte, // Latched readout byte
	output logic [7:0]      bootAreaSizeByte,   // Latched boot byte
	output logic [7:0]      watchdogOptionByte, // Latched watchdog byte
	output logic [7:0]      oscillatorSettleByte, // Latched oscillator byte
	output logic            brownoutEnable,     // Brownout comparator on
	output logic [2:0]      brownoutThreshold,  // Brownout comparator level
	output logic            referenceEnable,    // Internal reference on
	output logic            lvdCompEnable,      // Detector comparator on
	output logic [2:0]      lvdCompLevel,       // Detector comparator level
	output logic            lvdIrq,             // Detector interrupt flag
	output logic            lowPowerRegulatorMode, // Regulator in low-power mode
	output logic            windowDogHaltResetReq  // Window dog reset on halt
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers: three stages, change taken when stages two and three agree
	// The comparators sit in the analogue domain and may chatter near a
	// threshold; a level only counts once two stages agree, which costs four
	// clock edges of latency but keeps a single glitch from reaching reset

	logic [2:0] porSync;    // Power-on comparator pipeline
	logic [2:0] borSync;    // Brownout comparator pipeline
	logic [2:0] lvdSync;    // Detector comparator pipeline
	logic       porLow;     // Filtered power-on low
	logic       borLow;     // Filtered brownout low
	logic       lvdLow;     // Filtered detector low

	// Shift comparator levels in
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			porSync <= 3'h7;
			borSync <= 3'h7;
			lvdSync <= 3'h0;
		end else begin
			porSync <= {porSync[1:0], porBelow};
			borSync <= {borSync[1:0], brownoutBelow};
			lvdSync <= {lvdSync[1:0], lvdBelow};
		end
	end

	// Filtered levels; power-on and brownout take the safe low-supply value after reset, detector resets to not low
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			porLow <= 1'b1;
			borLow <= 1'b1;
			lvdLow <= 1'b0;
		end else begin
			if (porSync[1] == porSync[2]) begin
				porLow <= porSync[2];
			end
			if (borSync[1] == borSync[2]) begin
				borLow <= borSync[2];
			end
			if (lvdSync[1] == lvdSync[2]) begin
				lvdLow <= lvdSync[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Load sequencer
	// Bytes are fetched in index order, one per accepted strobe; a power-on
	// loss anywhere in the walk starts again from the first byte, so a
	// half-loaded set never reaches the decoders with the core running

	osc_load_state_t loadState;   // Sequencer state
	logic [2:0]      loadIndex;   // Byte being fetched
	logic            supplyGood;  // Supply above all active thresholds

	// Brownout is always active until options are loaded
	// Power-on comparator always holds reset; brownout only while brownoutEnable is set
	assign supplyGood = !porLow && !(borLow && brownoutEnable);

	// Walk the option bytes once the supply is good
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			loadState <= OSC_WAIT_SUPPLY;
			loadIndex <= OSC_IDX_READOUT;
		end else begin
			case (loadState)
				OSC_WAIT_SUPPLY: begin
					if (supplyGood) begin
						loadState <= OSC_FETCH;
						loadIndex <= OSC_IDX_READOUT;
					end
				end
				OSC_FETCH: begin
					// Power-on loss restarts the whole load
					if (porLow) begin
						loadState <= OSC_WAIT_SUPPLY;
					end else if (optReadValid) begin
						if (loadIndex == OSC_IDX_LAST) begin
							loadState <= OSC_DONE;
						end else begin
							loadIndex <= loadIndex + 3'h1;
						end
					end
				end
				OSC_DONE: begin
					// Options stay latched; reload only after power loss
					if (porLow) begin
						loadState <= OSC_WAIT_SUPPLY;
					end
				end
				default: begin
					loadState <= OSC_WAIT_SUPPLY;
				end
			endcase
		end
	end

	assign optReadStrobe = (loadState == OSC_FETCH) && !porLow;
	assign optReadIndex  = loadIndex;

	////////////////////////////////////////////////////////////////////////
	// Option byte latches; the reserved byte is fetched but not kept
	// The latches are not cleared on a reload: the core stays in reset until
	// the walk completes, so old values are never taken as valid settings

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			readoutProtectByte   <= OSC_RST_BYTE;
			bootAreaSizeByte     <= OSC_RST_BYTE;
			watchdogOptionByte   <= OSC_RST_BYTE;
			oscillatorSettleByte <= OSC_RST_BYTE;
		end else if (optReadStrobe && optReadValid) begin
			case (loadIndex)
				OSC_IDX_READOUT:  readoutProtectByte   <= optReadData;
				OSC_IDX_BOOT:     bootAreaSizeByte     <= optReadData;
				OSC_IDX_WATCHDOG: watchdogOptionByte   <= optReadData;
				OSC_IDX_OSC:      oscillatorSettleByte <= optReadData;
				default: begin
					// Reserved byte ignored
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoders
	// Pure decode of the latched bytes; nothing here is clocked, so every
	// setting follows its byte in the same cycle that the byte is latched

	// Map a two-bit settle code to a cycle count
	function automatic logic [12:0] settleCount(input logic [1:0] code);
		case (code)
			2'h0:    settleCount = OSC_SETTLE_C0;
			2'h1:    settleCount = OSC_SETTLE_C1;
			2'h2:    settleCount = OSC_SETTLE_C2;
			default: settleCount = OSC_SETTLE_C3;
		endcase
	endfunction : settleCount

	logic [2:0] borField;   // Raw brownout field of oscillator byte

	assign borField = oscillatorSettleByte[OSC_POS_BOR +: 3];

	// Combine latched bytes into decoded settings
	always_comb begin
		cfg.readoutLock   = (readoutProtectByte != OSC_READOUT_UNLOCK);
		cfg.bootAreaSize  = bootAreaSizeByte;
		cfg.bootProtectRw = (bootAreaSizeByte == OSC_BOOT_TWO);
		cfg.indepDogHwStart    = watchdogOptionByte[OSC_POS_INDEP_HW];
		cfg.indepDogHaltStop   = watchdogOptionByte[OSC_POS_INDEP_HALT];
		cfg.windowDogHwStart   = watchdogOptionByte[OSC_POS_WINDOW_HW];
		cfg.windowDogHaltReset = watchdogOptionByte[OSC_POS_WINDOW_HALT];
		cfg.fastOscSettleCount = settleCount(oscillatorSettleByte[OSC_POS_FAST_CNT +: 2]);
		cfg.slowOscSettleCount = settleCount(oscillatorSettleByte[OSC_POS_SLOW_CNT +: 2]);
		cfg.brownoutOff   = (borField == OSC_BOR_OFF);
		// Five levels; out-of-range codes keep the default
		cfg.brownoutLevel = (borField <= OSC_BOR_MAX) ? borField : OSC_BOR_DEFAULT;
	end

	////////////////////////////////////////////////////////////////////////
	// Brownout, reference and regulator control
	// Every control output is registered so the analogue side sees clean
	// levels; halt changes therefore take effect one edge after the request

	logic loaded;   // All options latched

	assign loaded = (loadState == OSC_DONE);

	// Brownout stays on with default level until load completes
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			brownoutEnable    <= 1'b1;
			brownoutThreshold <= OSC_BOR_DEFAULT;
		end else if (!loaded) begin
			brownoutEnable    <= 1'b1;
			brownoutThreshold <= OSC_BOR_DEFAULT;
		end else begin
			brownoutEnable    <= !cfg.brownoutOff && !(refOffInHalt && haltRequest);
			brownoutThreshold <= cfg.brownoutLevel;
		end
	end

	// Reference switched off only in halt when selected
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			referenceEnable <= 1'b1;
		end else begin
			referenceEnable <= !(loaded && refOffInHalt && haltRequest);
		end
	end

	// Regulator mode follows halt entry
	// Main mode serves run and both wait modes; only halt selects low power
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lowPowerRegulatorMode <= 1'b0;
		end else begin
			lowPowerRegulatorMode <= haltRequest;
		end
	end

	// Window dog reset request on halt entry when configured
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			windowDogHaltResetReq <= 1'b0;
		end else begin
			windowDogHaltResetReq <= loaded && haltRequest && cfg.windowDogHaltReset;
		end
	end

	// Core reset follows supply and load status
	// Held while loading so no decoded setting can change under a running core;
	// limitation: once brownout is switched off by option it no longer holds reset
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			coreReset <= 1'b1;
		end else begin
			coreReset <= !loaded || !supplyGood;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Low-voltage detector
	// Software owns enable, level and edge choice; the flag stays set until
	// cleared, and an edge in the clearing cycle keeps it set so none is lost

	logic lvdLowPrev;  // Previous filtered detector level

	// Comparator controls from software
	// Levels above the top one are clamped rather than wrapped
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lvdCompEnable <= 1'b0;
			lvdCompLevel  <= 3'h0;
		end else begin
			lvdCompEnable <= lvdEnable;
			lvdCompLevel  <= (lvdLevel > OSC_LVD_MAX) ? OSC_LVD_MAX : lvdLevel;
		end
	end

	// Edge history of the filtered detector level
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lvdLowPrev <= 1'b0;
		end else begin
			lvdLowPrev <= lvdLow;
		end
	end

	// Sticky flag; a crossing in the clearing cycle wins
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lvdIrq <= 1'b0;
		end else if (lvdCompEnable &&
			((lvdIrqOnFall && lvdLow && !lvdLowPrev) ||
			 (lvdIrqOnRise && !lvdLow && lvdLowPrev))) begin
			lvdIrq <= 1'b1;
		end else if (lvdIrqClear) begin
			lvdIrq <= 1'b0;
		end
	end

endmodule : osc_option_supply

`default_nettype wire

// file: tb/osc_flash_model.sv
// Purpose: Option byte store answering the loader fetch port
// Assumes: Index is held with the strobe until valid is seen
// Notes:   latency sets wait cycles, 0 gives back-to-back bytes
`timescale 1ns/1ns
`default_nettype none
module osc_flash_model (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        optReadStrobe,
	input  wire logic [2:0]  optReadIndex,
	input  wire logic [39:0] optionBytes,
	input  wire logic [1:0]  latency,
	output logic             optReadValid,
	output logic [7:0]       optReadData
);
	logic [1:0] waitCount; // Cycles the request has waited
	logic [7:0] lastData;  // Last byte handed over
	// Wait count restarts after every handover
	always_ff @(posedge clock) begin
		if (!reset_n || !optReadStrobe || optReadValid) waitCount <= 2'h0;
		else if (waitCount != 2'h3) waitCount <= waitCount + 2'h1;
	end
	// Remember the last byte so idle data can differ from it
	always_ff @(posedge clock) begin
		if (!reset_n) lastData <= 8'h5A;
		else if (optReadValid) lastData <= optReadData;
	end
	assign optReadValid = optReadStrobe && (waitCount >= latency);
	// Idle data is inverted so a stale byte never passes as good
	assign optReadData  = optReadValid ? optionBytes[8 * optReadIndex +: 8] : ~lastData;
endmodule : osc_flash_model
`default_nettype wire

// file: tb/osc_option_supply_sva.sv
// Purpose: Port checker for the option loader and supply logic
// Assumes: Bench holds haltRequest low while in reset
// Notes:   Bound to the design from the bench top file
`timescale 1ns/1ns
`default_nettype none
module osc_option_supply_sva
	import osc_cfg_pkg::*;
(
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic       porBelow,
	input wire logic       brownoutBelow,
	input wire logic       haltRequest,
	input wire logic       refOffInHalt,
	input wire logic       lvdEnable,
	input wire logic       lvdIrqOnFall,
	input wire logic       lvdIrqOnRise,
	input wire logic       optReadStrobe,
	input wire logic       coreReset,
	input wire osc_cfg_t   cfg,
	input wire logic [7:0] readoutProtectByte,
	input wire logic [7:0] bootAreaSizeByte,
	input wire logic [7:0] watchdogOptionByte,
	input wire logic [7:0] oscillatorSettleByte,
	input wire logic       brownoutEnable,
	input wire logic [2:0] brownoutThreshold,
	input wire logic       referenceEnable,
	input wire logic       lvdIrq,
	input wire logic       lowPowerRegulatorMode,
	input wire logic       windowDogHaltResetReq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Expected settle count per two-bit code
	function automatic logic [12:0] settle(input logic [1:0] code);
		return (code == 2'h0) ? 13'h0001 : (code == 2'h1) ? 13'h0010 : (code == 2'h2) ? 13'h0200 : 13'h1000;
	endfunction : settle
	////////////////////////////////////////////////////////////////////////////////
	a_por_reset:
		assert property (porBelow [*6] |-> coreReset) else $error("core left running on low supply");
	a_fetch_after_supply:
		assert property ($rose(optReadStrobe) |-> $past(!porBelow && !brownoutBelow, 2)) else $error("early fetch");
	a_bytes_stable:
		assert property (!coreReset |-> $stable(readoutProtectByte) && $stable(bootAreaSizeByte)
			&& $stable(watchdogOptionByte) && $stable(oscillatorSettleByte)) else $error("bytes moved in run");
	a_readout_decode:
		assert property (cfg.readoutLock == (readoutProtectByte != OSC_READOUT_UNLOCK)) else $error("readout lock");
	a_boot_decode:
		assert property (cfg.bootAreaSize == bootAreaSizeByte
			&& cfg.bootProtectRw == (bootAreaSizeByte == OSC_BOOT_TWO)) else $error("boot area decode");
	a_dog_bits:
		assert property ({cfg.windowDogHaltReset, cfg.windowDogHwStart, cfg.indepDogHaltStop, cfg.indepDogHwStart}
			== watchdogOptionByte[3:0]) else $error("watchdog bits");
	a_settle_decode:
		assert property (cfg.fastOscSettleCount == settle(oscillatorSettleByte[1:0])
			&& cfg.slowOscSettleCount == settle(oscillatorSettleByte[3:2])) else $error("settle decode");
	a_bor_level:
		assert property (!coreReset && $past(!coreReset) && oscillatorSettleByte[6:4] <= OSC_BOR_MAX
			|-> brownoutThreshold == oscillatorSettleByte[6:4]) else $error("brownout level");
	a_bor_off:
		assert property (!coreReset && $past(!coreReset) && oscillatorSettleByte[6:4] == OSC_BOR_OFF
			|-> !brownoutEnable) else $error("brownout not off");
	a_halt_lowpower:
		assert property (haltRequest |=> lowPowerRegulatorMode) else $error("regulator not low power");
	a_run_main:
		assert property (!haltRequest |=> !lowPowerRegulatorMode && referenceEnable) else $error("run mode");
	a_ref_off:
		assert property (haltRequest && refOffInHalt && !coreReset |=> !referenceEnable && !brownoutEnable)
			else $error("ref on");
	a_window_halt:
		assert property (haltRequest && cfg.windowDogHaltReset && !coreReset |=> windowDogHaltResetReq)
			else $error("window halt reset");
	a_lvd_source:
		assert property ($rose(lvdIrq) |-> $past(lvdEnable, 2) && $past(lvdIrqOnFall || lvdIrqOnRise))
			else $error("detector flag");
endmodule : osc_option_supply_sva
`default_nettype wire

// file: tb/tb_osc_option_supply.sv
// Purpose: Self-checking bench for the option loader and supply logic
// Assumes: Comparators are driven straight from the bench
// Notes:   Eight loads sweep brownout levels, settle codes and halt options
`timescale 1ns/1ns
`default_nettype none
module tb_osc_option_supply;
	import osc_cfg_pkg::*;
	logic clock = 1'b0, reset_n = 1'b0, porBelow = 1'b1, brownoutBelow = 1'b1, lvdBelow = 1'b0;
	logic haltRequest = 1'b0, lvdEnable = 1'b0, lvdIrqOnFall = 1'b0, lvdIrqOnRise = 1'b0;
	logic lvdIrqClear = 1'b0, refOffInHalt = 1'b0, optReadStrobe, optReadValid, coreReset;
	logic brownoutEnable, referenceEnable, lvdCompEnable, lvdIrq, lowPowerRegulatorMode, windowDogHaltResetReq;
	logic [2:0] lvdLevel = 3'h0, optReadIndex, brownoutThreshold, lvdCompLevel;
	logic [7:0] optReadData, readoutProtectByte, bootAreaSizeByte, watchdogOptionByte, oscillatorSettleByte;
	logic [39:0] optionBytes = 40'h0;
	logic [1:0]  latency = 2'h0;
	osc_cfg_t    cfg;
	int numErrors = 0, nCompared = 0, cycles = 0;
	int opt[5];                                      // Reference copy of the option bytes
	int settleTab[4] = '{1, 16, 512, 4096};
	int bootTab[4] = '{0, 1, 2, 255};
	logic [31:0] seed = 32'h61;                      // Xorshift state, starts at 97
	osc_option_supply osc_option_supply_inst (.clock, .reset_n, .porBelow, .brownoutBelow, .lvdBelow,
		.optReadStrobe, .optReadIndex, .optReadValid, .optReadData, .haltRequest, .lvdEnable, .lvdLevel,
		.lvdIrqOnFall, .lvdIrqOnRise, .lvdIrqClear, .refOffInHalt, .coreReset, .cfg, .readoutProtectByte,
		.bootAreaSizeByte, .watchdogOptionByte, .oscillatorSettleByte, .brownoutEnable, .brownoutThreshold,
		.referenceEnable, .lvdCompEnable, .lvdCompLevel, .lvdIrq, .lowPowerRegulatorMode, .windowDogHaltResetReq);
	osc_flash_model osc_flash_model_inst (.clock, .reset_n, .optReadStrobe, .optReadIndex, .optionBytes,
		.latency, .optReadValid, .optReadData);
	always #20 clock = ~clock;                       // 25 MHz
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic step(input int n);
		repeat (n) @(posedge clock);
	endtask : step
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkFlag(input logic got, input logic exp);
		chk({12'h0, got}, {12'h0, exp});
	endtask : chkFlag
	task automatic endOfTest();
		$display("compared %0d mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : endOfTest
	// Power cycle, then wait for the option load with the supply good
	task automatic load();
		int k;
		porBelow <= 1'b1;
		brownoutBelow <= 1'b1;
		step(6);
		porBelow <= 1'b0;
		step(8);
		@(negedge clock);
		chkFlag(optReadStrobe, 1'b0);
		chkFlag(coreReset, 1'b1);
		step(1);
		brownoutBelow <= 1'b0;
		for (k = 0; k < 200 && coreReset !== 1'b0; k++) begin
			@(negedge clock);
			if (optReadStrobe === 1'b1) chkFlag(coreReset, 1'b1);
		end
		chkFlag(coreReset, 1'b0);
	endtask : load
	// Ceiling well above eight loads of about sixty to seventy cycles each
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			numErrors++;
			endOfTest();
		end
	end
	initial begin
		int i, lvl;
		step(4);
		reset_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			lvl = i;
			opt[0] = i[0] ? 'hAA : (rnd() & 255);
			opt[1] = (i < 4) ? bootTab[i] : (rnd() & 255);
			opt[2] = rnd() & 255;
			opt[3] = rnd() & 255;
			opt[4] = (lvl << 4) | (i & 3) | ((~i & 3) << 2) | (rnd() & 128);
			optionBytes <= {8'(opt[4]), 8'(opt[3]), 8'(opt[2]), 8'(opt[1]), 8'(opt[0])};
			latency <= i[1:0];
			load();
			chk(13'(readoutProtectByte), 13'(opt[0]));
			chk(13'(bootAreaSizeByte), 13'(opt[1]));
			chk(13'(watchdogOptionByte), 13'(opt[3]));
			chk(13'(oscillatorSettleByte), 13'(opt[4]));
			chkFlag(cfg.readoutLock, opt[0] != 'hAA);
			chk({4'h0, cfg.bootProtectRw, cfg.bootAreaSize}, 13'(((opt[1] == 2) << 8) | opt[1]));
			chk(13'({cfg.windowDogHaltReset, cfg.windowDogHwStart, cfg.indepDogHaltStop, cfg.indepDogHwStart}),
				13'(opt[3] & 15));
			chk(cfg.fastOscSettleCount, 13'(settleTab[opt[4] & 3]));
			chk(cfg.slowOscSettleCount, 13'(settleTab[(opt[4] >> 2) & 3]));
			chk(13'(brownoutThreshold), 13'((lvl <= 4) ? lvl : 0));
			chkFlag(brownoutEnable, lvl != 7);
			step(1);
			refOffInHalt <= i[2];
			haltRequest <= 1'b1;
			step(2);
			@(negedge clock);
			chkFlag(lowPowerRegulatorMode, 1'b1);
			chkFlag(referenceEnable, !i[2]);
			chkFlag(brownoutEnable, lvl != 7 && !i[2]);
			chkFlag(windowDogHaltResetReq, opt[3][3]);
			step(1);
			haltRequest <= 1'b0;
			lvdEnable <= 1'b1;
			lvdLevel <= 3'(lvl);
			lvdIrqOnFall <= i[0];
			lvdIrqOnRise <= i[1];
			step(2);
			lvdBelow <= 1'b1;
			step(6);
			@(negedge clock);
			chkFlag(lowPowerRegulatorMode, 1'b0);
			chkFlag(lvdCompEnable, 1'b1);
			chk(13'(lvdCompLevel), 13'((lvl > 6) ? 6 : lvl));
			chkFlag(lvdIrq, i[0]);
			step(1);
			lvdIrqClear <= 1'b1;
			step(1);
			lvdIrqClear <= 1'b0;
			lvdBelow <= 1'b0;
			step(6);
			@(negedge clock);
			chkFlag(lvdIrq, i[1]);
			step(1);
			lvdIrqClear <= 1'b1;
			brownoutBelow <= 1'b1;
			step(1);
			lvdIrqClear <= 1'b0;
			step(5);
			@(negedge clock);
			chkFlag(coreReset, lvl != 7);
			chkFlag(lvdIrq, 1'b0);
			step(1);
		end
		endOfTest();
	end
endmodule : tb_osc_option_supply
bind osc_option_supply osc_option_supply_sva osc_option_supply_sva_inst (.clock, .reset_n, .porBelow,
	.brownoutBelow, .haltRequest, .refOffInHalt, .lvdEnable, .lvdIrqOnFall, .lvdIrqOnRise, .optReadStrobe,
	.coreReset, .cfg, .readoutProtectByte, .bootAreaSizeByte, .watchdogOptionByte, .oscillatorSettleByte,
	.brownoutEnable, .brownoutThreshold, .referenceEnable, .lvdIrq, .lowPowerRegulatorMode,
	.windowDogHaltResetReq);
`default_nettype wire
